// >>> watchdog_interval_timer.sv
/*
 * watchdog / interval timer: 8-bit up-counter on a selectable prescaled
 * clock, internal reset stretch, interval interrupt, APB register slave.
 * assumes oscillator and subclock arrive as asynchronous pins and the
 * APB master runs on clk.
 */
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps

// Notes on behaviour
// - counter wrap from ff to 00 sets overflow flag bit 7
// - in watchdog mode the internal reset clears the overflow flag
// - flag clears on read-while-set then write 0; writing 1 does nothing
// - mode bit 5 written only when bit 6 written 0; bit 6 reads 1
// - mode 0 is watchdog, mode 1 is interval timer
// - irq enable bit 3 written only when bit 4 written 0; bit 4 reads 1
// - interval mode forwards interrupt only when enable bit is 1
// - counter is 8-bit, readable, writable, zero after reset
// - watchdog mode wrap issues internal reset and sets reset-cause flag
// - clock select: oscillator/2048, subclock/16,/256, reserved, system/64../8192
// - counting runs from reset; run bit changes only by gated write; gate needs earlier write
// - overflow on first tick at ff; reset held 512 oscillator cycles
// - written counter value is the start point, period 1 to 256
// - interval mode sets the flag on every overflow, interrupt only when enable bit is 1, no reset
// - flag sets in the same cycle as reset or interrupt
// - counter advances while run enable is 1, holds while 0
// - counter writes accepted only while counter write enable is 1
// - watchdog reset leaves reset-cause flag; pin reset or gated write clears
module watchdog_interval_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic onchipOscillatorClock,
  input wire logic subClock,
  output logic internalReset,
  output logic intervalIrq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] counter_reg;
  logic [3:0] clockSel_reg;
  logic runEnable_reg;
  logic counterWriteEnable_reg;
  logic controlWriteGate_reg;
  logic resetCause_reg;
  logic overflowFlag_reg;
  logic timerModeSelect_reg;
  logic overflowIrqEnable_reg;
  logic ovfReadArmed_reg;
  logic wdReset_reg;
  logic [8:0] stretch_reg;
  logic [12:0] sysPre_reg;
  logic [10:0] oscPre_reg;
  logic [7:0] subPre_reg;
  logic oscSyncA, oscSyncB, oscPrev;
  logic subSyncA, subSyncB, subPrev;
  logic oscEdge, subEdge, countTick, overflow;
  logic [12:0] sysMask;
  logic setupPhase, access, wrAccess;
  logic wrRun, wrStatus, wrCounter, wrClock, rdStatus;
  logic [7:0] rdByte;
  logic mapped;
  logic errReg;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oscSyncA <= 1'b0;
      oscSyncB <= 1'b0;
      oscPrev <= 1'b0;
      subSyncA <= 1'b0;
      subSyncB <= 1'b0;
      subPrev <= 1'b0;
    end else begin
      oscSyncA <= onchipOscillatorClock;
      oscSyncB <= oscSyncA;
      oscPrev <= oscSyncB;
      subSyncA <= subClock;
      subSyncB <= subSyncA;
      subPrev <= subSyncB;
    end
  end

  assign oscEdge = oscSyncB & ~oscPrev;
  assign subEdge = subSyncB & ~subPrev;

  // ------------------------------------------------------------
  // prescalers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sysPre_reg <= '0;
      oscPre_reg <= '0;
      subPre_reg <= '0;
    end else begin
      sysPre_reg <= sysPre_reg + 13'h0001;
      if (oscEdge) begin
        oscPre_reg <= oscPre_reg + 11'h001;
      end
      if (subEdge) begin
        subPre_reg <= subPre_reg + 8'h01;
      end
    end
  end

  assign sysMask = wdt_pkg::SYS_PRESCALE_MASK >> (3'd7 - clockSel_reg[2:0]);

  always_comb begin
    case (clockSel_reg)
      4'h0, 4'h1, 4'h2, 4'h3: countTick = oscEdge && oscPre_reg == wdt_pkg::OSC_DIV2048_LAST;
      4'h4: countTick = subEdge && subPre_reg[3:0] == wdt_pkg::SUB_DIV16_LAST;
      4'h5: countTick = subEdge && subPre_reg == wdt_pkg::SUB_DIV256_LAST;
      4'h6, 4'h7: countTick = 1'b0;
      default: countTick = (sysPre_reg & sysMask) == sysMask;
    endcase
  end

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign setupPhase = psel & ~penable;
  assign access = psel & penable;
  assign wrAccess = access & pwrite;
  assign wrRun = wrAccess && paddr == wdt_pkg::RUN_CONTROL_OFS;
  assign wrStatus = wrAccess && paddr == wdt_pkg::STATUS_MODE_OFS;
  assign wrCounter = wrAccess && paddr == wdt_pkg::UP_COUNTER_OFS;
  assign wrClock = wrAccess && paddr == wdt_pkg::CLOCK_SELECT_OFS;
  assign rdStatus = access && !pwrite && paddr == wdt_pkg::STATUS_MODE_OFS;
  assign mapped = paddr == wdt_pkg::RUN_CONTROL_OFS || paddr == wdt_pkg::STATUS_MODE_OFS
    || paddr == wdt_pkg::UP_COUNTER_OFS || paddr == wdt_pkg::CLOCK_SELECT_OFS;
  assign pready = 1'b1;
  assign pslverr = access & errReg;

  always_comb begin
    case (paddr)
      wdt_pkg::RUN_CONTROL_OFS: rdByte = {1'b1, counterWriteEnable_reg, 1'b1,
        controlWriteGate_reg, 1'b1, runEnable_reg, 1'b1, resetCause_reg};
      wdt_pkg::STATUS_MODE_OFS: rdByte = {overflowFlag_reg, 1'b1, timerModeSelect_reg,
        1'b1, overflowIrqEnable_reg, 3'b111};
      wdt_pkg::UP_COUNTER_OFS: rdByte = counter_reg;
      wdt_pkg::CLOCK_SELECT_OFS: rdByte = {4'hf, clockSel_reg};
      default: rdByte = 8'h00;
    endcase
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
      errReg <= 1'b0;
    end else if (setupPhase) begin
      prdata <= {24'h000000, rdByte};
      errReg <= ~mapped;
    end
  end

  // ------------------------------------------------------------
  // run control register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      runEnable_reg <= wdt_pkg::RUN_RESET;
      counterWriteEnable_reg <= wdt_pkg::CWE_RESET;
      controlWriteGate_reg <= wdt_pkg::GATE_RESET;
    end else if (wdReset_reg) begin
      runEnable_reg <= wdt_pkg::RUN_RESET;
      counterWriteEnable_reg <= wdt_pkg::CWE_RESET;
      controlWriteGate_reg <= wdt_pkg::GATE_RESET;
    end else if (wrRun) begin
      if (!pwdata[wdt_pkg::CWE_INHIBIT_BIT]) begin
        counterWriteEnable_reg <= pwdata[wdt_pkg::CWE_BIT];
      end
      if (!pwdata[wdt_pkg::GATE_INHIBIT_BIT]) begin
        controlWriteGate_reg <= pwdata[wdt_pkg::GATE_BIT];
      end
      if (!pwdata[wdt_pkg::RUN_INHIBIT_BIT] && controlWriteGate_reg) begin
        runEnable_reg <= pwdata[wdt_pkg::RUN_BIT];
      end
    end
  end

  // reset cause survives the stretched watchdog reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resetCause_reg <= 1'b0;
    end else if (overflow && !timerModeSelect_reg) begin
      resetCause_reg <= 1'b1;
    end else if (wrRun && !wdReset_reg && !pwdata[wdt_pkg::CAUSE_INHIBIT_BIT]
        && controlWriteGate_reg && !pwdata[wdt_pkg::CAUSE_BIT]) begin
      resetCause_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // status / mode register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timerModeSelect_reg <= wdt_pkg::MODE_RESET;
      overflowIrqEnable_reg <= wdt_pkg::IRQEN_RESET;
    end else if (wdReset_reg) begin
      timerModeSelect_reg <= wdt_pkg::MODE_RESET;
      overflowIrqEnable_reg <= wdt_pkg::IRQEN_RESET;
    end else if (wrStatus) begin
      if (!pwdata[wdt_pkg::MODE_INHIBIT_BIT]) begin
        timerModeSelect_reg <= pwdata[wdt_pkg::MODE_BIT];
      end
      if (!pwdata[wdt_pkg::IRQEN_INHIBIT_BIT]) begin
        overflowIrqEnable_reg <= pwdata[wdt_pkg::IRQEN_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      overflowFlag_reg <= 1'b0;
      ovfReadArmed_reg <= 1'b0;
    end else if (overflow) begin
      overflowFlag_reg <= 1'b1;
      ovfReadArmed_reg <= 1'b0;
    end else if (wdReset_reg) begin
      overflowFlag_reg <= 1'b0;
      ovfReadArmed_reg <= 1'b0;
    end else if (rdStatus && prdata[wdt_pkg::OVF_BIT]) begin
      ovfReadArmed_reg <= 1'b1;
    end else if (wrStatus) begin
      if (ovfReadArmed_reg && !pwdata[wdt_pkg::OVF_BIT]) begin
        overflowFlag_reg <= 1'b0;
      end
      ovfReadArmed_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // counter and clock select
  // ------------------------------------------------------------
  // a refused counter write does not block the wrap
  assign overflow = countTick && runEnable_reg && !wdReset_reg
    && !(wrCounter && counterWriteEnable_reg)
    && counter_reg == wdt_pkg::COUNTER_MAX;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      counter_reg <= wdt_pkg::COUNTER_RESET;
    end else if (wdReset_reg) begin
      counter_reg <= wdt_pkg::COUNTER_RESET;
    end else if (wrCounter && counterWriteEnable_reg) begin
      counter_reg <= pwdata[7:0];
    end else if (countTick && runEnable_reg) begin
      counter_reg <= counter_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clockSel_reg <= wdt_pkg::CLOCK_SELECT_RESET;
    end else if (wdReset_reg) begin
      clockSel_reg <= wdt_pkg::CLOCK_SELECT_RESET;
    end else if (wrClock) begin
      clockSel_reg <= pwdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // reset stretch and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdReset_reg <= 1'b0;
      stretch_reg <= '0;
    end else if (overflow && !timerModeSelect_reg) begin
      wdReset_reg <= 1'b1;
      stretch_reg <= '0;
    end else if (wdReset_reg && oscEdge) begin
      stretch_reg <= stretch_reg + 9'h001;
      if (stretch_reg == wdt_pkg::RESET_STRETCH_LAST) begin
        wdReset_reg <= 1'b0;
      end
    end
  end

  assign internalReset = wdReset_reg;
  // request follows the flag while interval mode and irq enable are both set
  assign intervalIrq = overflowFlag_reg & timerModeSelect_reg
    & overflowIrqEnable_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ovf_flag_set_a: assert property (overflow |=> overflowFlag_reg)
    else $error("overflow did not set the flag");
  wrap_sets_flag_a: assert property (counter_reg == 8'hff && !wdReset_reg
    && !(wrCounter && counterWriteEnable_reg) ##1 counter_reg == 8'h00 |-> overflowFlag_reg)
    else $error("counter wrap left the flag clear");
  wd_reset_issue_a: assert property (overflow && !timerModeSelect_reg
    |=> wdReset_reg && resetCause_reg && overflowFlag_reg)
    else $error("watchdog overflow did not reset");
  flag_auto_clear_a: assert property ($rose(wdReset_reg) |=> !overflowFlag_reg)
    else $error("internal reset left the flag set");
  flag_write_one_a: assert property (wrStatus && pwdata[7] && overflowFlag_reg
    && !wdReset_reg |=> overflowFlag_reg)
    else $error("writing 1 cleared the flag");
  inhibit_readback_a: assert property (access && rdStatus
    |-> prdata[6] && prdata[4] && prdata[2:0] == 3'b111)
    else $error("inhibit bits not read as 1");
  mode_gate_a: assert property (wrStatus && pwdata[6] && !wdReset_reg
    |=> $stable(timerModeSelect_reg))
    else $error("mode changed while inhibited");
  irqen_gate_a: assert property (wrStatus && pwdata[4] && !wdReset_reg
    |=> $stable(overflowIrqEnable_reg))
    else $error("irq enable changed while inhibited");
  interval_irq_a: assert property (overflow && timerModeSelect_reg
    && overflowIrqEnable_reg |=> intervalIrq && !wdReset_reg)
    else $error("interval overflow raised no interrupt");
  counter_hold_a: assert property (!runEnable_reg && !wrCounter && !wdReset_reg
    |=> $stable(counter_reg))
    else $error("counter moved while stopped");
  counter_write_a: assert property (wrCounter && counterWriteEnable_reg && !wdReset_reg
    |=> counter_reg == $past(pwdata[7:0]))
    else $error("counter write not taken");
  counter_inc_a: assert property (countTick && runEnable_reg && !wrCounter
    && !wdReset_reg |=> counter_reg == $past(counter_reg) + 8'h01)
    else $error("counter did not increment");
  cause_keep_a: assert property (wdReset_reg |=> resetCause_reg)
    else $error("reset cause lost in watchdog reset");
  stretch_len_a: assert property ($fell(wdReset_reg)
    |-> $past(stretch_reg) == 9'h1ff)
    else $error("reset stretch length wrong");
endmodule : watchdog_interval_timer

// >>> wdt_pkg.sv
/*
 * constants for the watchdog / interval timer: register offsets, field
 * positions, reset values and count lengths.
 * assumes an APB master with 32-bit data and byte addresses.
 */
package wdt_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] RUN_CONTROL_OFS = 8'h00;
  localparam logic [7:0] STATUS_MODE_OFS = 8'h04;
  localparam logic [7:0] UP_COUNTER_OFS = 8'h08;
  localparam logic [7:0] CLOCK_SELECT_OFS = 8'h0c;
  // ------------------------------------------------------------
  // run control fields
  // ------------------------------------------------------------
  localparam int CWE_INHIBIT_BIT = 7;
  localparam int CWE_BIT = 6;
  localparam int GATE_INHIBIT_BIT = 5;
  localparam int GATE_BIT = 4;
  localparam int RUN_INHIBIT_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int CAUSE_INHIBIT_BIT = 1;
  localparam int CAUSE_BIT = 0;
  // ------------------------------------------------------------
  // status / mode fields
  // ------------------------------------------------------------
  localparam int OVF_BIT = 7;
  localparam int MODE_INHIBIT_BIT = 6;
  localparam int MODE_BIT = 5;
  localparam int IRQEN_INHIBIT_BIT = 4;
  localparam int IRQEN_BIT = 3;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic RUN_RESET = 1'b1;
  localparam logic CWE_RESET = 1'b0;
  localparam logic GATE_RESET = 1'b0;
  localparam logic MODE_RESET = 1'b0;
  localparam logic IRQEN_RESET = 1'b0;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [3:0] CLOCK_SELECT_RESET = 4'h0;
  localparam logic [7:0] COUNTER_MAX = 8'hff;
  // ------------------------------------------------------------
  // prescalers and reset stretch
  // ------------------------------------------------------------
  localparam logic [12:0] SYS_PRESCALE_MASK = 13'h1fff;
  localparam logic [10:0] OSC_DIV2048_LAST = 11'h7ff;
  localparam logic [3:0] SUB_DIV16_LAST = 4'hf;
  localparam logic [7:0] SUB_DIV256_LAST = 8'hff;
  localparam logic [8:0] RESET_STRETCH_LAST = 9'h1ff;
endpackage : wdt_pkg

// >>> test_watchdog_interval_timer.sv
/*
 * self-checking testbench for the watchdog / interval timer: APB register
 * access, write gates, interval interrupt, count clock taps, internal reset.
 * assumes the design and wdt_pkg are compiled first; bench drives both clock pins.
 */
`timescale 1ns/1ps

module test_watchdog_interval_timer;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic onchipOscillatorClock = 1'b0;
  logic subClock = 1'b0;
  logic internalReset;
  logic intervalIrq;
  logic oscRun = 1'b0;
  logic subRun = 1'b0;
  logic [1:0] oscDiv = 2'h0;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  // oscillator and subclock pins at a quarter of clk, each only while enabled
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (oscRun || subRun) begin
      oscDiv <= oscDiv + 2'h1;
    end
    if (oscRun) begin
      onchipOscillatorClock <= oscDiv[1];
    end
    if (subRun) begin
      subClock <= oscDiv[1];
    end
  end

  watchdog_interval_timer u_dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .onchipOscillatorClock(onchipOscillatorClock),
    .subClock(subClock), .internalReset(internalReset), .intervalIrq(intervalIrq)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(name, rd, {24'h000000, exp});
  endtask : rdchk

  task wait_hi(input logic which, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while ((which ? internalReset : intervalIrq) !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      n_errors++;
      $display("MISMATCH wait_hi expected 1 seen 0");
    end
  endtask : wait_hi

  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task test_reset;
    rdchk("run_ctrl", wdt_pkg::RUN_CONTROL_OFS, 8'hae);
    rdchk("status", wdt_pkg::STATUS_MODE_OFS, 8'h57);
    rdchk("counter", wdt_pkg::UP_COUNTER_OFS, 8'h00);
    rdchk("clk_sel", wdt_pkg::CLOCK_SELECT_OFS, 8'hf0);
    rdchk("unmapped", 8'h10, 8'h00);
    check("slverr", err, 1'b1);
    check("pready", pready, 1'b1);
    $display("test_reset done");
  endtask : test_reset

  task test_run;
    logic [7:0] c;
    apb(1'b1, wdt_pkg::UP_COUNTER_OFS, 8'h55);
    rdchk("cnt_locked", wdt_pkg::UP_COUNTER_OFS, 8'h00);
    apb(1'b1, wdt_pkg::RUN_CONTROL_OFS, 8'h6a);
    rdchk("cwe_on", wdt_pkg::RUN_CONTROL_OFS, 8'hee);
    apb(1'b1, wdt_pkg::UP_COUNTER_OFS, 8'h55);
    rdchk("cnt_written", wdt_pkg::UP_COUNTER_OFS, 8'h55);
    apb(1'b1, wdt_pkg::RUN_CONTROL_OFS, 8'ha2);
    rdchk("run_no_gate", wdt_pkg::RUN_CONTROL_OFS, 8'hee);
    apb(1'b1, wdt_pkg::RUN_CONTROL_OFS, 8'hda);
    apb(1'b1, wdt_pkg::RUN_CONTROL_OFS, 8'ha2);
    rdchk("run_off", wdt_pkg::RUN_CONTROL_OFS, 8'hfa);
    apb(1'b1, wdt_pkg::CLOCK_SELECT_OFS, 8'h08);
    repeat (300) @(posedge clk);
    rdchk("cnt_held", wdt_pkg::UP_COUNTER_OFS, 8'h55);
    apb(1'b1, wdt_pkg::RUN_CONTROL_OFS, 8'ha6);
    repeat (300) @(posedge clk);
    apb(1'b0, wdt_pkg::UP_COUNTER_OFS, 8'h00);
    c = rd[7:0] - 8'h55;
    check("cnt_runs", (c >= 8'h04 && c <= 8'h06), 1'b1);
    $display("test_run done");
  endtask : test_run

  task test_interval;
    apb(1'b1, wdt_pkg::STATUS_MODE_OFS, 8'hfe);
    rdchk("inhibited", wdt_pkg::STATUS_MODE_OFS, 8'h57);
    apb(1'b1, wdt_pkg::STATUS_MODE_OFS, 8'h28);
    rdchk("mode_irq_on", wdt_pkg::STATUS_MODE_OFS, 8'h7f);
    apb(1'b1, wdt_pkg::UP_COUNTER_OFS, 8'hff);
    wait_hi(1'b0, 200);
    check("no_reset", internalReset, 1'b0);
    apb(1'b1, wdt_pkg::STATUS_MODE_OFS, 8'hd0);
    apb(1'b1, wdt_pkg::STATUS_MODE_OFS, 8'h40);
    @(negedge clk);
    check("irq_masked", intervalIrq, 1'b0);
    rdchk("flag_kept", wdt_pkg::STATUS_MODE_OFS, 8'hf7);
    apb(1'b1, wdt_pkg::STATUS_MODE_OFS, 8'h28);
    rdchk("flag_clr", wdt_pkg::STATUS_MODE_OFS, 8'h7f);
    check("irq_low", intervalIrq, 1'b0);
    $display("test_interval done");
  endtask : test_interval

  task test_select;
    int div;
    int t1;
    for (int k = 8; k < 16; k++) begin
      div = 64 << (k - 8);
      apb(1'b1, wdt_pkg::CLOCK_SELECT_OFS, 8'(k));
      apb(1'b1, wdt_pkg::UP_COUNTER_OFS, 8'hff);
      wait_hi(1'b0, 2 * div + 40);
      t1 = cyc;
      apb(1'b1, wdt_pkg::UP_COUNTER_OFS, 8'hff);
      apb(1'b0, wdt_pkg::STATUS_MODE_OFS, 8'h00);
      apb(1'b1, wdt_pkg::STATUS_MODE_OFS, 8'h50);
      @(negedge clk);
      check("irq_cleared", intervalIrq, 1'b0);
      wait_hi(1'b0, div + 40);
      check("tap_period", cyc - t1, div);
      apb(1'b0, wdt_pkg::STATUS_MODE_OFS, 8'h00);
      apb(1'b1, wdt_pkg::STATUS_MODE_OFS, 8'h50);
    end
    $display("test_select done");
  endtask : test_select

  task test_subclock;
    int div;
    int t1;
    logic [7:0] c;
    subRun <= 1'b1;
    for (int s = 4; s < 6; s++) begin
      div = (s == 4) ? 64 : 1024;
      apb(1'b1, wdt_pkg::CLOCK_SELECT_OFS, 8'(s));
      apb(1'b1, wdt_pkg::UP_COUNTER_OFS, 8'hff);
      wait_hi(1'b0, 2 * div + 40);
      t1 = cyc;
      apb(1'b1, wdt_pkg::UP_COUNTER_OFS, 8'hff);
      apb(1'b0, wdt_pkg::STATUS_MODE_OFS, 8'h00);
      apb(1'b1, wdt_pkg::STATUS_MODE_OFS, 8'h50);
      wait_hi(1'b0, div + 40);
      check("sub_period", cyc - t1, div);
      apb(1'b0, wdt_pkg::STATUS_MODE_OFS, 8'h00);
      apb(1'b1, wdt_pkg::STATUS_MODE_OFS, 8'h50);
    end
    apb(1'b1, wdt_pkg::CLOCK_SELECT_OFS, 8'h06);
    apb(1'b0, wdt_pkg::UP_COUNTER_OFS, 8'h00);
    c = rd[7:0];
    repeat (200) @(posedge clk);
    rdchk("reserved_hold", wdt_pkg::UP_COUNTER_OFS, c);
    subRun <= 1'b0;
    $display("test_subclock done");
  endtask : test_subclock

  task test_watchdog;
    int n;
    n = 0;
    apb(1'b1, wdt_pkg::STATUS_MODE_OFS, 8'h10);
    apb(1'b1, wdt_pkg::CLOCK_SELECT_OFS, 8'h08);
    apb(1'b1, wdt_pkg::UP_COUNTER_OFS, 8'hff);
    oscRun <= 1'b1;
    wait_hi(1'b1, 200);
    check("wd_no_irq", intervalIrq, 1'b0);
    while (internalReset === 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check("reset_len", (n >= 2040 && n <= 2056), 1'b1);
    oscRun <= 1'b0;
    rdchk("cause_set", wdt_pkg::RUN_CONTROL_OFS, 8'haf);
    rdchk("flag_auto", wdt_pkg::STATUS_MODE_OFS, 8'h57);
    rdchk("sel_back", wdt_pkg::CLOCK_SELECT_OFS, 8'hf0);
    apb(1'b1, wdt_pkg::RUN_CONTROL_OFS, 8'ha8);
    rdchk("cause_nogate", wdt_pkg::RUN_CONTROL_OFS, 8'haf);
    apb(1'b1, wdt_pkg::RUN_CONTROL_OFS, 8'hda);
    apb(1'b1, wdt_pkg::RUN_CONTROL_OFS, 8'ha8);
    rdchk("cause_clr", wdt_pkg::RUN_CONTROL_OFS, 8'hbe);
    $display("test_watchdog done");
  endtask : test_watchdog

  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    test_reset;
    test_run;
    test_interval;
    test_select;
    test_subclock;
    test_watchdog;
    final_report;
  end

  initial begin
    #1600000;
    n_errors++;
    $display("MISMATCH run_time expected done seen hang");
    final_report;
  end
endmodule : test_watchdog_interval_timer
